/* File: inc/dcd_map.svh */
/*
  Register indices, field positions and reset values of the channel dividers.
  Assumes a bus slave that places index N at byte address 4*N.
*/
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define DCD_IDX_CNT_ONE 12'h193
`define DCD_IDX_CTL_ONE 12'h194
`define DCD_IDX_RTE_ONE 12'h195
`define DCD_IDX_CNT_TWO 12'h196
`define DCD_IDX_CTL_TWO 12'h197
`define DCD_IDX_STATUS 12'h1A0
`define DCD_IDX_SRC_SEL 12'h1E1

// ==========================================================
// field positions
`define DCD_LOW_MSB 7
`define DCD_LOW_LSB 4
`define DCD_HIGH_MSB 3
`define DCD_HIGH_LSB 0
`define DCD_BYPASS_BIT 7
`define DCD_NOSYNC_BIT 6
`define DCD_FORCE_BIT 5
`define DCD_START_BIT 4
`define DCD_PHASE_MSB 3
`define DCD_PHASE_LSB 0
`define DCD_DIRECT_BIT 1
`define DCD_DUTY_CORRECTION_DISABLE_BIT 0

// ==========================================================
// reset values and source select codes
`define DCD_RST_CNT_ONE 8'h00
`define DCD_RST_CTL_ONE 8'h00
`define DCD_RST_RTE_ONE 8'h00
`define DCD_RST_CNT_TWO 8'h00
`define DCD_RST_CTL_TWO 8'h80
`define DCD_RST_SRC_SEL 2'h0
`define DCD_SRC_OSC 2'h2
`define DCD_SRC_EXT 2'h0
`define DCD_SRC_NONE 2'h1

`endif

/* File: inc/dcd_pkg.sv */
/*
  Types shared by the channel divider files.
  Assumes nothing of its surroundings.
*/
package dcd_pkg;

  // ========================================================
  // per-divider configuration as decoded from the registers
  typedef struct packed {
    logic [3:0] low_cycles;
    logic [3:0] high_cycles;
    logic bypass;
    logic nosync;
    logic force_high;
    logic start_high;
    logic [3:0] phase;
    logic dcc_off;
  } dcd_cfg_t;

  typedef enum logic {DCD_ST_PHASE, DCD_ST_RUN} dcd_state_t;

endpackage

/* File: rtl/dcd_divider.sv */
/*
  One channel divider: phase wait, low/high counting, bypass, force, and
  duty-cycle regeneration of the passed-through clock.
  Assumes in_level is already synchronised to clock and toggles slower
  than clock/2; each rising edge of it is one divider input cycle.
*/
`timescale 1ns/10ps
`include "dcd_map.svh"

module dcd_divider #(
  parameter int PER_W = 8
) (
  input wire logic clock, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic in_level, // synchronised divider input clock
  input wire logic sync_active, // chip-level sync asserted
  input wire dcd_pkg::dcd_cfg_t cfg, // divider configuration
  output logic out_level // divider output
);

  if (PER_W < 2) begin : g_bad_per
    $error("dcd_divider: PER_W must be at least 2");
  end

  logic in_prev_reg;
  logic rise;
  logic hold;
  logic forced;
  dcd_pkg::dcd_state_t state_reg;
  logic [3:0] cnt_reg;
  logic level_reg;
  logic [PER_W-1:0] pcnt_reg;
  logic [PER_W-1:0] per_reg;
  logic regen;
  logic [4:0] seg_cnt_reg;
  logic [7:0] seg_cfg_reg;

  assign rise = in_level & ~in_prev_reg;
  assign hold = sync_active & ~cfg.nosync;
  assign forced = sync_active & cfg.nosync;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_prev_reg <= 1'b0;
    end else begin
      in_prev_reg <= in_level;
    end
  end

  // ========================================================
  // counting
  // bypass restarts from the phase wait, so leaving it is glitch-free
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= dcd_pkg::DCD_ST_PHASE;
      cnt_reg <= 4'h0;
      level_reg <= 1'b0;
    end else if (hold || cfg.bypass) begin
      state_reg <= dcd_pkg::DCD_ST_PHASE;
      cnt_reg <= cfg.phase;
      level_reg <= cfg.start_high;
    end else if (rise) begin
      unique case (state_reg)
        dcd_pkg::DCD_ST_PHASE: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= dcd_pkg::DCD_ST_RUN;
            cnt_reg <= level_reg ? cfg.high_cycles : cfg.low_cycles;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        dcd_pkg::DCD_ST_RUN: begin
          if (cnt_reg == 4'h0) begin
            level_reg <= ~level_reg;
            cnt_reg <= level_reg ? cfg.low_cycles : cfg.high_cycles;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
      endcase
    end
  end

  // ========================================================
  // duty-cycle regeneration: high for half the measured input period
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pcnt_reg <= '0;
      per_reg <= '0;
    end else if (cfg.bypass && !cfg.dcc_off) begin
      if (rise) begin
        per_reg <= pcnt_reg + PER_W'(1);
        pcnt_reg <= '0;
      end else if (pcnt_reg != '1) begin
        pcnt_reg <= pcnt_reg + PER_W'(1);
      end
    end else begin
      pcnt_reg <= '0;
      per_reg <= '0;
    end
  end

  assign regen = rise | (pcnt_reg < (per_reg >> 1));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_level <= 1'b0;
    end else if (forced) begin
      out_level <= cfg.force_high;
    end else if (cfg.bypass) begin
      out_level <= cfg.dcc_off ? in_level : regen;
    end else begin
      out_level <= level_reg;
    end
  end

  // ========================================================
  // checking helpers and assertions
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seg_cnt_reg <= 5'h00;
      seg_cfg_reg <= 8'h00;
    end else if (state_reg != dcd_pkg::DCD_ST_RUN || hold || cfg.bypass) begin
      seg_cnt_reg <= 5'h00;
      seg_cfg_reg <= {cfg.low_cycles, cfg.high_cycles};
    end else if (rise) begin
      seg_cnt_reg <= (cnt_reg == 4'h0) ? 5'h00 : seg_cnt_reg + 5'h01;
      // counts in force when a segment begins; later writes apply to the next one
      if (cnt_reg == 4'h0) begin
        seg_cfg_reg <= {cfg.low_cycles, cfg.high_cycles};
      end
    end
  end

  sequence run_edge_s;
    state_reg == dcd_pkg::DCD_ST_RUN && rise && !hold && !cfg.bypass && cnt_reg == 4'h0;
  endsequence

  low_span_a: assert property (@(posedge clock) disable iff (!arst_n)
    run_edge_s and !level_reg |-> seg_cnt_reg == {1'b0, seg_cfg_reg[7:4]})
    else $error("low phase length wrong");
  high_span_a: assert property (@(posedge clock) disable iff (!arst_n)
    run_edge_s and level_reg |-> seg_cnt_reg == {1'b0, seg_cfg_reg[3:0]})
    else $error("high phase length wrong");
  bypass_pass_a: assert property (@(posedge clock) disable iff (!arst_n)
    cfg.bypass && cfg.dcc_off && !forced |=> out_level == $past(in_level))
    else $error("bypass does not pass input");
  force_out_a: assert property (@(posedge clock) disable iff (!arst_n)
    forced |=> out_level == $past(cfg.force_high))
    else $error("forced level not driven");
  start_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    hold ##1 hold |-> level_reg == $past(cfg.start_high) && state_reg == dcd_pkg::DCD_ST_PHASE)
    else $error("start level not held in sync");
  phase_wait_a: assert property (@(posedge clock) disable iff (!arst_n)
    state_reg == dcd_pkg::DCD_ST_PHASE && !hold && !cfg.bypass && rise && cnt_reg != 4'h0
    |=> state_reg == dcd_pkg::DCD_ST_PHASE)
    else $error("phase wait cut short");
  run_toggle_a: assert property (@(posedge clock) disable iff (!arst_n)
    run_edge_s |=> level_reg != $past(level_reg))
    else $error("divider did not toggle");

endmodule

/* File: rtl/dcd_top.sv */
/*
  Two channel dividers with an APB register slave, pin synchronisers and
  the direct route of the oscillator or external clock to channel one.
  Assumes the oscillator, external clock and sync pins are asynchronous
  and run well below half the system clock rate.
*/
`timescale 1ns/10ps
`include "dcd_map.svh"

module dcd_top #(
  parameter int ADDR_W = 16
) (
  input wire logic clock, // system clock, 100 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic osc_clk_pin, // internal_oscillator clock level
  input wire logic ext_clk_pin, // external clock input level
  input wire logic sync_pin_n, // chip-level sync, active low
  output logic channel_output_a, // channel one, first output
  output logic channel_output_b, // channel one, second output
  output logic div_two_out // divider two output
);

  if (ADDR_W < 14) begin : g_bad_addr
    $error("dcd_top: ADDR_W must be at least 14");
  end

  // ========================================================
  // pin synchronisers
  logic [2:0] pin_raw;
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;

  assign pin_raw = {sync_pin_n, ext_clk_pin, osc_clk_pin};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        meta_reg[i] <= 1'b0;
        sync_reg[i] <= 1'b0;
      end else begin
        meta_reg[i] <= pin_raw[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  logic osc_level;
  logic ext_level;
  logic sync_active;

  assign osc_level = sync_reg[0];
  assign ext_level = sync_reg[1];
  // reset synchroniser state reads as sync asserted, harmless: it restarts
  assign sync_active = ~sync_reg[2];

  // ========================================================
  // registers
  logic [7:0] cnt_one_reg;
  logic [7:0] ctl_one_reg;
  logic [7:0] rte_one_reg;
  logic [7:0] cnt_two_reg;
  logic [7:0] ctl_two_reg;
  logic [1:0] src_sel_reg;

  logic wr_en;
  logic rd_setup;
  logic hit_cnt_one;
  logic hit_ctl_one;
  logic hit_rte_one;
  logic hit_cnt_two;
  logic hit_ctl_two;
  logic hit_status;
  logic hit_src_sel;
  logic hit_any;
  // declared early: the status word reads it before the route logic
  logic direct_on;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
    addr_is = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  assign hit_cnt_one = addr_is(paddr, `DCD_IDX_CNT_ONE);
  assign hit_ctl_one = addr_is(paddr, `DCD_IDX_CTL_ONE);
  assign hit_rte_one = addr_is(paddr, `DCD_IDX_RTE_ONE);
  assign hit_cnt_two = addr_is(paddr, `DCD_IDX_CNT_TWO);
  assign hit_ctl_two = addr_is(paddr, `DCD_IDX_CTL_TWO);
  assign hit_status = addr_is(paddr, `DCD_IDX_STATUS);
  assign hit_src_sel = addr_is(paddr, `DCD_IDX_SRC_SEL);
  assign hit_any = hit_cnt_one | hit_ctl_one | hit_rte_one | hit_cnt_two
    | hit_ctl_two | hit_status | hit_src_sel;

  // zero-wait slave: every access phase completes in its first cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit_any;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_one_reg <= `DCD_RST_CNT_ONE;
      ctl_one_reg <= `DCD_RST_CTL_ONE;
      rte_one_reg <= `DCD_RST_RTE_ONE;
    end else if (wr_en) begin
      if (hit_cnt_one) begin
        cnt_one_reg <= pwdata[7:0];
      end
      if (hit_ctl_one) begin
        ctl_one_reg <= pwdata[7:0];
      end
      if (hit_rte_one) begin
        rte_one_reg <= {6'h00, pwdata[`DCD_DIRECT_BIT], pwdata[`DCD_DUTY_CORRECTION_DISABLE_BIT]};
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_two_reg <= `DCD_RST_CNT_TWO;
      ctl_two_reg <= `DCD_RST_CTL_TWO;
    end else if (wr_en) begin
      if (hit_cnt_two) begin
        cnt_two_reg <= pwdata[7:0];
      end
      if (hit_ctl_two) begin
        ctl_two_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      src_sel_reg <= `DCD_RST_SRC_SEL;
    end else if (wr_en && hit_src_sel) begin
      src_sel_reg <= pwdata[1:0];
    end
  end

  // ========================================================
  // read data, captured in the setup cycle
  logic [7:0] status_val;
  logic [7:0] rd_val;

  assign status_val = {4'h0, direct_on, sync_active, div_two_out, channel_output_a};

  always_comb begin
    rd_val = 8'h00;
    if (hit_cnt_one) begin
      rd_val = cnt_one_reg;
    end
    if (hit_ctl_one) begin
      rd_val = ctl_one_reg;
    end
    if (hit_rte_one) begin
      rd_val = rte_one_reg;
    end
    if (hit_cnt_two) begin
      rd_val = cnt_two_reg;
    end
    if (hit_ctl_two) begin
      rd_val = ctl_two_reg;
    end
    if (hit_status) begin
      rd_val = status_val;
    end
    if (hit_src_sel) begin
      rd_val = {6'h00, src_sel_reg};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rd_val};
    end
  end

  // ========================================================
  // source selection and direct route
  // the divider input and the direct route pick the same source, so the
  // direct route is simply divider one forced into pass-through
  logic src_level;

  assign src_level = (src_sel_reg == `DCD_SRC_OSC) ? osc_level : ext_level;
  assign direct_on = rte_one_reg[`DCD_DIRECT_BIT]
    & (src_sel_reg != `DCD_SRC_NONE);

  // ========================================================
  // divider configurations
  dcd_pkg::dcd_cfg_t cfg_one;
  dcd_pkg::dcd_cfg_t cfg_two;

  always_comb begin
    cfg_one.low_cycles = cnt_one_reg[`DCD_LOW_MSB:`DCD_LOW_LSB];
    cfg_one.high_cycles = cnt_one_reg[`DCD_HIGH_MSB:`DCD_HIGH_LSB];
    cfg_one.bypass = ctl_one_reg[`DCD_BYPASS_BIT] | direct_on;
    cfg_one.nosync = ctl_one_reg[`DCD_NOSYNC_BIT];
    cfg_one.force_high = ctl_one_reg[`DCD_FORCE_BIT];
    cfg_one.start_high = ctl_one_reg[`DCD_START_BIT];
    cfg_one.phase = ctl_one_reg[`DCD_PHASE_MSB:`DCD_PHASE_LSB];
    cfg_one.dcc_off = rte_one_reg[`DCD_DUTY_CORRECTION_DISABLE_BIT];
  end

  always_comb begin
    cfg_two.low_cycles = cnt_two_reg[`DCD_LOW_MSB:`DCD_LOW_LSB];
    cfg_two.high_cycles = cnt_two_reg[`DCD_HIGH_MSB:`DCD_HIGH_LSB];
    cfg_two.bypass = ctl_two_reg[`DCD_BYPASS_BIT];
    cfg_two.nosync = ctl_two_reg[`DCD_NOSYNC_BIT];
    cfg_two.force_high = ctl_two_reg[`DCD_FORCE_BIT];
    cfg_two.start_high = ctl_two_reg[`DCD_START_BIT];
    cfg_two.phase = ctl_two_reg[`DCD_PHASE_MSB:`DCD_PHASE_LSB];
    // no routing register for divider two: correction stays enabled
    cfg_two.dcc_off = 1'b0;
  end

  // ========================================================
  // dividers
  logic div_one_out;

  dcd_divider #(
    .PER_W(8)
  ) u_div_one (
    .clock(clock),
    .arst_n(arst_n),
    .in_level(src_level),
    .sync_active(sync_active),
    .cfg(cfg_one),
    .out_level(div_one_out)
  );

  dcd_divider #(
    .PER_W(8)
  ) u_div_two (
    .clock(clock),
    .arst_n(arst_n),
    .in_level(src_level),
    .sync_active(sync_active),
    .cfg(cfg_two),
    .out_level(div_two_out)
  );

  // both outputs of the pair share divider one
  assign channel_output_a = div_one_out;
  assign channel_output_b = div_one_out;

  // ========================================================
  // assertions
  reset_bypass_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(arst_n) |-> ctl_two_reg[`DCD_BYPASS_BIT] && !ctl_one_reg[`DCD_BYPASS_BIT])
    else $error("bypass reset values wrong");
  no_route_a: assert property (@(posedge clock) disable iff (!arst_n)
    src_sel_reg == `DCD_SRC_NONE && !ctl_one_reg[`DCD_BYPASS_BIT] |-> !cfg_one.bypass)
    else $error("direct route active on select 01b");
  direct_osc_a: assert property (@(posedge clock) disable iff (!arst_n)
    direct_on && rte_one_reg[`DCD_DUTY_CORRECTION_DISABLE_BIT] && sync_reg[2]
    && src_sel_reg == `DCD_SRC_OSC ##1 $stable(src_sel_reg) && $stable(rte_one_reg)
    |-> channel_output_a == $past(osc_level))
    else $error("oscillator not routed to output");
  pair_same_a: assert property (@(posedge clock) disable iff (!arst_n)
    channel_output_a == channel_output_b)
    else $error("channel pair outputs differ");
  count_two_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && hit_cnt_two |=> cfg_two.low_cycles == $past(pwdata[7:4])
    && cfg_two.high_cycles == $past(pwdata[3:0]))
    else $error("divider two counts not taken");
  sync_ignore_a: assert property (@(posedge clock) disable iff (!arst_n)
    cfg_one.nosync && !cfg_one.bypass && sync_active ##1 sync_active && $stable(cnt_one_reg)
    |-> channel_output_a == $past(cfg_one.force_high))
    else $error("sync not ignored as set");
  apb_err_a: assert property (@(posedge clock) disable iff (!arst_n)
    psel && penable && !hit_any |-> pready && pslverr)
    else $error("unmapped access not refused");

  // ========================================================
  // register bus assertions, then route and sync output checks
  // software must read back exactly what the dividers are run from
  reset_values_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(arst_n) |-> cnt_one_reg == `DCD_RST_CNT_ONE && rte_one_reg == `DCD_RST_RTE_ONE
    && cnt_two_reg == `DCD_RST_CNT_TWO && src_sel_reg == `DCD_RST_SRC_SEL)
    else $error("register reset values wrong");
  write_one_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && hit_cnt_one |=> cnt_one_reg == $past(pwdata[7:0]))
    else $error("count one write lost");
  ctl_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && hit_ctl_one |=> ctl_one_reg == $past(pwdata[7:0]))
    else $error("control one write lost");
  write_two_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && hit_ctl_two |=> ctl_two_reg == $past(pwdata[7:0]))
    else $error("control two write lost");
  rte_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && hit_rte_one |=> rte_one_reg == {6'h00, $past(pwdata[1:0])})
    else $error("routing write lost");
  src_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en && hit_src_sel |=> src_sel_reg == $past(pwdata[1:0]))
    else $error("source select write lost");
  read_capture_a: assert property (@(posedge clock) disable iff (!arst_n)
    rd_setup && hit_cnt_two |=> prdata == {24'h00_0000, $past(cnt_two_reg)})
    else $error("count two read wrong");
  unmapped_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
    psel && penable && pwrite && !hit_any
    |=> $stable(cnt_one_reg) && $stable(ctl_one_reg) && $stable(ctl_two_reg))
    else $error("unmapped write changed a register");
  unmapped_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    rd_setup && !hit_any |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  ready_access_a: assert property (@(posedge clock) disable iff (!arst_n)
    psel && penable |-> pready && (pslverr == !hit_any))
    else $error("access phase not answered");
  route_off_a: assert property (@(posedge clock) disable iff (!arst_n)
    !rte_one_reg[`DCD_DIRECT_BIT] |-> cfg_one.bypass == ctl_one_reg[`DCD_BYPASS_BIT])
    else $error("divider one not on the pair");
  direct_ext_a: assert property (@(posedge clock) disable iff (!arst_n)
    direct_on && rte_one_reg[`DCD_DUTY_CORRECTION_DISABLE_BIT] && sync_reg[2]
    && src_sel_reg == `DCD_SRC_EXT ##1 $stable(src_sel_reg) && $stable(rte_one_reg)
    |-> channel_output_a == $past(ext_level))
    else $error("external clock not routed to output");
  status_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    rd_setup && hit_status |=> prdata[3:2] == {$past(direct_on), $past(sync_active)})
    else $error("status read wrong");
  sync_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (sync_active && !cfg_one.nosync && !cfg_one.bypass) [*3]
    |-> channel_output_a == $past(cfg_one.start_high, 2))
    else $error("sync does not hold start level");

endmodule

/* File: verification/dcd_src_model.sv */
/*
  Clock sources at the far side of the channel dividers: the oscillator
  and the external clock input, both as plain levels on the pins.
  Assumes nothing of the dividers; edges are unrelated in phase to clock.
*/
`timescale 1ns/10ps

module dcd_src_model #(
  parameter real OSC_HALF = 50.3,
  parameter real EXT_HALF = 80.7
) (
  output logic osc_clk, // oscillator clock level
  output logic ext_clk // external clock input level
);
  // ==========================================================
  // sources
  // both run free: a clock input is never gated between uses
  initial begin
    osc_clk = 1'b0;
    #3.3;
    forever #(OSC_HALF) osc_clk = ~osc_clk;
  end

  // odd start offset keeps the two sources apart from each other
  initial begin
    ext_clk = 1'b0;
    #7.1;
    forever #(EXT_HALF) ext_clk = ~ext_clk;
  end
endmodule

/* File: verification/differential_channel_clock_dividers_tb_top.sv */
/*
  Self-checking bench of the channel dividers: apb register access and
  output timing measured in ns against the source periods.
  Assumes the source model runs both clock pins free, below clock/4.
*/
`timescale 1ns/10ps
`include "dcd_map.svh"

module differential_channel_clock_dividers_tb_top;
  localparam real T_EXT = 161.4;
  localparam real T_OSC = 100.6;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic sync_pin_n = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, osc_clk_pin, ext_clk_pin;
  logic channel_output_a, channel_output_b, div_two_out;
  logic [1:0] sel = 2'd0;
  logic mon;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int cmp_count = 0;
  int n, m;
  realtime hi, lo, t0;
  logic [11:0] idx_t[6] = '{`DCD_IDX_CNT_ONE, `DCD_IDX_CTL_ONE, `DCD_IDX_RTE_ONE,
    `DCD_IDX_CNT_TWO, `DCD_IDX_CTL_TWO, `DCD_IDX_SRC_SEL};
  logic [7:0] rst_t[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  logic [7:0] ctl_t[6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h60, 8'h50};
  logic lvl_t[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  always #5 clock = ~clock;
  assign mon = (sel == 2'd0) ? channel_output_a : (sel == 2'd1) ? channel_output_b : div_two_out;

  dcd_top i_dcd_top (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_clk_pin(osc_clk_pin), .ext_clk_pin(ext_clk_pin),
    .sync_pin_n(sync_pin_n), .channel_output_a(channel_output_a),
    .channel_output_b(channel_output_b), .div_two_out(div_two_out));

  dcd_src_model #(.OSC_HALF(T_OSC / 2), .EXT_HALF(T_EXT / 2)) i_dcd_src_model (
    .osc_clk(osc_clk_pin), .ext_clk(ext_clk_pin));

  // ==========================================================
  // helpers
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic chk_t(input string name, input real exp, input real got, input real tol = 30.0);
    cmp_count++;
    if (got < exp - tol || got > exp + tol) begin
      errors++;
      $display("[ERR] %s exp %0.1f got %0.1f", name, exp, got);
    end
  endtask

  // upper write data is random: the slave must ignore it
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'($urandom()), d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // first rise is skipped and timing starts at the second, so count changes have settled
  task automatic meas(input logic [1:0] s);
    sel = s;
    repeat (2) @(posedge mon);
    t0 = $realtime;
    @(negedge mon);
    hi = $realtime - t0;
    t0 = $realtime;
    @(posedge mon);
    lo = $realtime - t0;
  endtask

  function automatic real src_t(input int s);
    return (s == 2) ? T_OSC : T_EXT;
  endfunction

  // ==========================================================
  // tests
  initial begin
    n = $urandom(32'h2E78);
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, idx_t[i], 8'h00);
      chk("reset value", {24'h0, rst_t[i]}, rd);
      chk("mapped err", 32'h0, {31'h0, err});
    end
    apb(1'b1, 12'h100, 8'h5A);
    apb(1'b0, 12'h100, 8'h00);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    meas(2'd2);
    chk_t("div two reset period", T_EXT, hi + lo);
    meas(2'd0);
    chk_t("div one reset period", 2 * T_EXT, hi + lo);
    apb(1'b1, `DCD_IDX_CTL_TWO, 8'h00);
    for (int k = 0; k < 4; k++) begin
      n = (k == 0) ? 15 : $urandom_range(0, 15);
      m = (k == 0) ? 15 : $urandom_range(0, 15);
      apb(1'b1, `DCD_IDX_CNT_ONE, {n[3:0], m[3:0]});
      apb(1'b1, `DCD_IDX_CNT_TWO, {m[3:0], n[3:0]});
      apb(1'b0, `DCD_IDX_CNT_ONE, 8'h00);
      chk("count readback", {24'h0, n[3:0], m[3:0]}, rd);
      meas(2'd0);
      chk_t("div one high", (m + 1) * T_EXT, hi);
      chk_t("div one low", (n + 1) * T_EXT, lo);
      meas(2'd1);
      chk_t("channel b period", (n + m + 2) * T_EXT, hi + lo);
      meas(2'd2);
      chk_t("div two high", (n + 1) * T_EXT, hi);
      chk_t("div two low", (m + 1) * T_EXT, lo);
    end
    apb(1'b1, `DCD_IDX_RTE_ONE, 8'hFF);
    apb(1'b0, `DCD_IDX_RTE_ONE, 8'h00);
    chk("route bits", 32'h3, rd);
    apb(1'b1, `DCD_IDX_CNT_ONE, 8'h31);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, `DCD_IDX_SRC_SEL, 8'(s));
      apb(1'b1, `DCD_IDX_RTE_ONE, 8'h00);
      meas(2'd1);
      chk_t("route off period", 6 * src_t(s), hi + lo);
      // correction off on routed sources lets the pass-through be checked exactly
      apb(1'b1, `DCD_IDX_RTE_ONE, (s == 1) ? 8'h02 : 8'h03);
      meas(2'd0);
      chk_t("route on period", (s == 1) ? 6 * T_EXT : src_t(s), hi + lo);
    end
    apb(1'b0, `DCD_IDX_STATUS, 8'h00);
    chk("status route", 32'h2, {30'h0, rd[3:2]});
    apb(1'b1, `DCD_IDX_RTE_ONE, 8'h00);
    apb(1'b1, `DCD_IDX_SRC_SEL, 8'h00);
    sync_pin_n <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `DCD_IDX_CTL_ONE, ctl_t[i]);
      repeat (40) @(posedge clock);
      for (int c = 0; c < 200; c++) begin
        @(negedge clock);
        chk("held level", {31'h0, lvl_t[i]}, {31'h0, channel_output_a});
      end
    end
    apb(1'b1, `DCD_IDX_CNT_ONE, 8'h00);
    for (int p = 0; p < 16; p += 15) begin
      @(posedge clock);
      sync_pin_n <= 1'b0;
      apb(1'b1, `DCD_IDX_CTL_ONE, 8'(p));
      repeat (20) @(posedge clock);
      sync_pin_n <= 1'b1;
      t0 = $realtime;
      sel = 2'd0;
      @(posedge mon);
      hi = $realtime - t0;
      chk_t("phase start", (p + 1.5) * T_EXT + 50.0, hi, T_EXT / 2 + 40.0);
    end
    apb(1'b1, `DCD_IDX_CTL_ONE, 8'h80);
    meas(2'd0);
    chk_t("div one bypass period", T_EXT, hi + lo);
    // second reset in mid-run must restore the bypass of divider two
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b0, `DCD_IDX_CTL_TWO, 8'h00);
    chk("ctl two after reset", 32'h80, rd);
    stop_test();
  end

  // longest measured period is 32 source cycles; the run fits well inside
  initial begin
    #900_000;
    errors++;
    stop_test();
  end
endmodule
